// >>> hdl/pdec_pkg.sv
// Purpose: constants and types shared by the power-down entry control block
// Assumes: 100 MHz ref_clk, plain register port with 4-bit byte address
// Notes:   offsets are byte addresses of 32-bit words
`default_nettype none
package pdec_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] WAKE_EN_OFFSET = 4'h4;
  localparam logic [3:0] WAKE_LVL_OFFSET = 4'h8;
  localparam logic [3:0] STATUS_OFFSET = 4'hC;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL_WAKE_SEL_BIT = 0;
  localparam int CTRL_TWC_BIT = 1;
  localparam int CTRL_MUX_BIT = 2;
  localparam int CTRL_FIX_BIT = 3;
  localparam int CTRL_WDT_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h18;
  localparam logic [7:0] WAKE_EN_RESET = 8'h00;
  localparam logic [7:0] WAKE_LVL_RESET = 8'h00;
  localparam logic [7:0] IGNORED_CNT_RESET = 8'h00;
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_NMI_BIT = 4;
  localparam int STATUS_WAKE_BIT = 5;
  localparam int STATUS_CNT_LSB = 8;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic wdt_enable;
    logic fix_enable;
    logic mux_bus;
    logic tristate_wait_ctl;
    logic powerdown_wake_select;
  } pdec_ctrl_type;

  typedef enum logic [2:0] {
    PDEC_RUN = 3'b000,
    PDEC_DRAIN = 3'b001,
    PDEC_QUASI = 3'b010,
    PDEC_PDOWN = 3'b011
  } pdec_state_type;

endpackage : pdec_pkg
`default_nettype wire

// >>> hdl/pdec_power_down_entry_control.sv
// Purpose: decides whether a power-down instruction enters power-down
// Assumes: cpu decode pulses power_down_instr for one cycle per instruction
// Notes:   fix_enable clear reproduces the quasi-idle fetch stall
`timescale 1ns/1ps
`default_nettype none
module pdec_power_down_entry_control #(
  parameter int WAKE_PINS = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic power_down_instr,
  input wire logic next_fetch_external,
  input wire logic prev_ext_write,
  input wire logic ext_write_pending,
  input wire logic prefetch_pending,
  input wire logic nmi_n,
  input wire logic [WAKE_PINS-1:0] port_two,
  input wire logic watchdog_overflow,
  output logic fetch_enable,
  output logic irq_service_enable,
  output logic periph_event_xfer_enable,
  output logic power_down_active,
  output logic quasi_idle,
  output logic instr_ignored,
  output logic device_reset_req
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [WAKE_PINS:0] pins_sync;
  logic nmi_high;
  logic [WAKE_PINS-1:0] port_two_sync;

  pdec_sync #(
    .WIDTH(WAKE_PINS + 1),
    .INIT({1'b1, {WAKE_PINS{1'b0}}})
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({nmi_n, port_two}),
    .sync_out(pins_sync)
  );

  assign nmi_high = pins_sync[WAKE_PINS];
  assign port_two_sync = pins_sync[WAKE_PINS-1:0];

  // ****************************************************************
  // registers
  // ****************************************************************
  pdec_pkg::pdec_ctrl_type ctrl_reg;
  pdec_pkg::pdec_ctrl_type ctrl_next;
  logic [WAKE_PINS-1:0] wake_en_reg;
  logic [WAKE_PINS-1:0] wake_en_next;
  logic [WAKE_PINS-1:0] wake_lvl_reg;
  logic [WAKE_PINS-1:0] wake_lvl_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0] ignored_cnt_reg;
  logic [7:0] ignored_cnt_next;
  pdec_pkg::pdec_state_type state_reg;
  pdec_pkg::pdec_state_type state_next;
  logic ignored_reg;
  logic ignored_next;
  logic wdt_reset_reg;
  logic wdt_reset_next;

  logic wake_pin_active;
  logic wake_blocks;
  logic stall_now;
  logic bus_busy;

  // ****************************************************************
  // wake condition
  // ****************************************************************
  // a pin is active when it matches its programmed level
  assign wake_pin_active =
      |(wake_en_reg & ~(port_two_sync ^ wake_lvl_reg));
  assign wake_blocks = ctrl_reg.powerdown_wake_select ?
      wake_pin_active :
      nmi_high;
  assign bus_busy = ext_write_pending | prefetch_pending;
  // the stall happens only when following code comes from outside
  assign stall_now = next_fetch_external &
      ((ctrl_reg.mux_bus & ~ctrl_reg.tristate_wait_ctl) |
       prev_ext_write);

  // ****************************************************************
  // register port
  // ****************************************************************
  always_comb begin
    ctrl_next = ctrl_reg;
    wake_en_next = wake_en_reg;
    wake_lvl_next = wake_lvl_reg;
    rdata_next = 32'h0000_0000;
    if (reg_write) begin
      unique case (reg_addr)
        pdec_pkg::CTRL_OFFSET: begin
          ctrl_next = reg_wdata[pdec_pkg::CTRL_WDT_BIT:0];
        end
        pdec_pkg::WAKE_EN_OFFSET: begin
          wake_en_next = reg_wdata[WAKE_PINS-1:0];
        end
        pdec_pkg::WAKE_LVL_OFFSET: begin
          wake_lvl_next = reg_wdata[WAKE_PINS-1:0];
        end
        default: begin
        end
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        pdec_pkg::CTRL_OFFSET: begin
          rdata_next[pdec_pkg::CTRL_WDT_BIT:0] = ctrl_reg;
        end
        pdec_pkg::WAKE_EN_OFFSET: begin
          rdata_next[WAKE_PINS-1:0] = wake_en_reg;
        end
        pdec_pkg::WAKE_LVL_OFFSET: begin
          rdata_next[WAKE_PINS-1:0] = wake_lvl_reg;
        end
        pdec_pkg::STATUS_OFFSET: begin
          rdata_next[pdec_pkg::STATUS_STATE_LSB +: 3] = state_reg;
          rdata_next[pdec_pkg::STATUS_NMI_BIT] = nmi_high;
          rdata_next[pdec_pkg::STATUS_WAKE_BIT] = wake_blocks;
          rdata_next[pdec_pkg::STATUS_CNT_LSB +: 8] = ignored_cnt_reg;
        end
        default: begin
          // unmapped offsets read as zero
        end
      endcase
    end
  end

  // ****************************************************************
  // entry sequencer
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    ignored_next = 1'b0;
    ignored_cnt_next = ignored_cnt_reg;
    // watchdog acts in every state, quasi-idle included
    wdt_reset_next = watchdog_overflow & ctrl_reg.wdt_enable;
    unique case (state_reg)
      pdec_pkg::PDEC_RUN: begin
        if (power_down_instr) begin
          // fault conditions are sampled with the instruction itself
          if (ctrl_reg.fix_enable && bus_busy) begin
            state_next = pdec_pkg::PDEC_DRAIN;
          end else if (!wake_blocks) begin
            state_next = pdec_pkg::PDEC_PDOWN;
          end else if (!ctrl_reg.fix_enable && stall_now) begin
            state_next = pdec_pkg::PDEC_QUASI;
          end else begin
            ignored_next = 1'b1;
            ignored_cnt_next = ignored_cnt_reg + 8'h01;
          end
        end
      end
      pdec_pkg::PDEC_DRAIN: begin
        // fetch held off until the bus is quiet, then decide once
        if (!bus_busy) begin
          if (!wake_blocks) begin
            state_next = pdec_pkg::PDEC_PDOWN;
          end else begin
            state_next = pdec_pkg::PDEC_RUN;
            ignored_next = 1'b1;
            ignored_cnt_next = ignored_cnt_reg + 8'h01;
          end
        end
      end
      pdec_pkg::PDEC_QUASI: begin
        // only a low nmi leaves; the wake-select pins do not
        if (!nmi_high) begin
          state_next = pdec_pkg::PDEC_PDOWN;
        end
      end
      pdec_pkg::PDEC_PDOWN: begin
        // woken by the same source that would have blocked entry
        if (wake_blocks) begin
          state_next = pdec_pkg::PDEC_RUN;
        end
      end
      default: begin
        state_next = pdec_pkg::PDEC_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= pdec_pkg::CTRL_RESET;
      wake_en_reg <= pdec_pkg::WAKE_EN_RESET;
      wake_lvl_reg <= pdec_pkg::WAKE_LVL_RESET;
      rdata_reg <= 32'h0000_0000;
      ignored_cnt_reg <= pdec_pkg::IGNORED_CNT_RESET;
      state_reg <= pdec_pkg::PDEC_RUN;
      ignored_reg <= 1'b0;
      wdt_reset_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      wake_en_reg <= wake_en_next;
      wake_lvl_reg <= wake_lvl_next;
      rdata_reg <= rdata_next;
      ignored_cnt_reg <= ignored_cnt_next;
      state_reg <= state_next;
      ignored_reg <= ignored_next;
      wdt_reset_reg <= wdt_reset_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata = rdata_reg;
  assign fetch_enable = (state_reg == pdec_pkg::PDEC_RUN);
  assign irq_service_enable =
      (state_reg == pdec_pkg::PDEC_RUN);
  assign periph_event_xfer_enable =
      (state_reg == pdec_pkg::PDEC_RUN);
  assign quasi_idle = (state_reg == pdec_pkg::PDEC_QUASI);
  assign power_down_active = (state_reg == pdec_pkg::PDEC_PDOWN);
  assign instr_ignored = ignored_reg;
  assign device_reset_req = wdt_reset_reg;

endmodule : pdec_power_down_entry_control
`default_nettype wire

// >>> hdl/pdec_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to ref_clk
// Notes:   output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pdec_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  always_comb begin
    // per-bit: a level only counts once two later stages agree
    out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      out_reg <= INIT;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule : pdec_sync
`default_nettype wire

// >>> test/pdec_bus_model.sv
// Purpose: external bus model, write and prefetch still in flight
// Assumes: start pulse loads a busy count
// Notes: write ends one cycle before the prefetch
`timescale 1ns/1ps
`default_nettype none
module pdec_bus_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [3:0] len,
  output logic ext_write_pending,
  output logic prefetch_pending
);
  logic [3:0] cnt_reg;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) cnt_reg <= 4'h0;
    else if (start) cnt_reg <= len;
    else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
  end
  assign ext_write_pending = cnt_reg > 4'h1;
  assign prefetch_pending = cnt_reg != 4'h0;
endmodule : pdec_bus_model
`default_nettype wire

// >>> test/pdec_chk_asserts.sv
// Purpose: port checker for power-down entry control
// Assumes: one clock domain, async active-low resetn
// Notes: bound to the entry control module, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module pdec_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic power_down_instr,
  input wire logic nmi_n,
  input wire logic watchdog_overflow,
  input wire logic fetch_enable,
  input wire logic irq_service_enable,
  input wire logic periph_event_xfer_enable,
  input wire logic power_down_active,
  input wire logic quasi_idle,
  input wire logic instr_ignored,
  input wire logic device_reset_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic stop;
  assign stop = !fetch_enable && !irq_service_enable
    && !periph_event_xfer_enable;
  // synchroniser plus one state cycle fit inside the window below
  sequence nmi_held;
    quasi_idle && !nmi_n ##1 !nmi_n [*5];
  endsequence
  // back-to-back instructions may give back-to-back pulses
  sequence ignore_cause;
    fetch_enable && ($past(power_down_instr) || !$past(fetch_enable));
  endsequence
  AST_QUASI_STOP:
    assert property (quasi_idle |-> stop)
    else $error("quasi-idle with enables high");
  AST_PDOWN_STOP:
    assert property (power_down_active |-> stop && !quasi_idle)
    else $error("power-down with enables high");
  AST_QUASI_CAUSE:
    assert property ($rose(quasi_idle) |-> $past(power_down_instr))
    else $error("quasi-idle without instruction");
  AST_NMI_EXIT:
    assert property (nmi_held |-> ##[0:4] power_down_active)
    else $error("nmi low did not leave quasi-idle");
  AST_WDT_RESET:
    assert property ($rose(device_reset_req) |-> $past(watchdog_overflow))
    else $error("device reset without overflow");
  AST_IGNORE_PULSE:
    assert property (instr_ignored |-> ignore_cause)
    else $error("ignored pulse without cause");
  AST_NO_REENTRY:
    assert property ((quasi_idle || power_down_active) && power_down_instr
      |=> !instr_ignored)
    else $error("instruction acted on outside run");
  AST_RDATA_ONE:
    assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule : pdec_chk
bind pdec_power_down_entry_control pdec_chk i_chk (.ref_clk, .resetn,
  .reg_read, .reg_rdata, .power_down_instr, .nmi_n, .watchdog_overflow,
  .fetch_enable, .irq_service_enable, .periph_event_xfer_enable,
  .power_down_active, .quasi_idle, .instr_ignored, .device_reset_req);
`default_nettype wire

// >>> test/tb_top.sv
// Purpose: self-checking bench for power-down entry control
// Assumes: 100 MHz ref_clk, async active-low resetn
// Notes: pins settle through a synchroniser before each instruction
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic power_down_instr = 1'b0;
  logic next_fetch_external = 1'b0;
  logic prev_ext_write = 1'b0;
  logic nmi_n = 1'b1;
  logic [7:0] port_two = 8'h00;
  logic watchdog_overflow = 1'b0;
  logic bus_go = 1'b0;
  logic [31:0] reg_rdata, rd;
  logic ext_write_pending, prefetch_pending, fetch_enable;
  logic irq_service_enable, periph_event_xfer_enable, power_down_active;
  logic quasi_idle, instr_ignored, device_reset_req;
  logic [5:0] outs;
  int n_fail = 0;
  int n_checks = 0;
  assign outs = {fetch_enable, irq_service_enable,
    periph_event_xfer_enable, power_down_active, quasi_idle, instr_ignored};
  always #5 ref_clk = ~ref_clk;
  pdec_power_down_entry_control #(.WAKE_PINS(8)) i_dut (.ref_clk, .resetn,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .power_down_instr, .next_fetch_external, .prev_ext_write,
    .ext_write_pending, .prefetch_pending, .nmi_n, .port_two,
    .watchdog_overflow, .fetch_enable, .irq_service_enable,
    .periph_event_xfer_enable, .power_down_active, .quasi_idle,
    .instr_ignored, .device_reset_req);
  pdec_bus_model i_bus (.ref_clk, .resetn, .start(bus_go), .len(4'h6),
    .ext_write_pending, .prefetch_pending);
  // ******
  // tasks
  // ******
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rd_reg
  task automatic pd(input logic ne, input logic pw, input logic [5:0] e);
    @(posedge ref_clk);
    power_down_instr <= 1'b1;
    next_fetch_external <= ne;
    prev_ext_write <= pw;
    @(posedge ref_clk);
    power_down_instr <= 1'b0;
    #1 chk({26'h0, outs}, {26'h0, e});
  endtask : pd
  // pins are asynchronous: give the synchroniser time to agree
  task automatic pins(input logic n, input logic [7:0] p);
    @(posedge ref_clk);
    nmi_n <= n;
    port_two <= p;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : pins
  task automatic rst;
    @(posedge ref_clk);
    resetn <= 1'b0;
    nmi_n <= 1'b1;
    port_two <= 8'h00;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask : rst
  task automatic wdog(input logic e);
    @(posedge ref_clk);
    watchdog_overflow <= 1'b1;
    @(posedge ref_clk);
    watchdog_overflow <= 1'b0;
    #1 chk({31'h0, device_reset_req}, {31'h0, e});
  endtask : wdog
  task automatic bus_kick;
    @(posedge ref_clk);
    bus_go <= 1'b1;
    @(posedge ref_clk);
    bus_go <= 1'b0;
  endtask : bus_kick
  task automatic t_regs;
    rd_reg(pdec_pkg::CTRL_OFFSET);
    chk(rd, 32'h18);
    // read data stand one cycle only
    @(posedge ref_clk);
    #1 chk(reg_rdata, 32'h0);
    wr(pdec_pkg::WAKE_EN_OFFSET, 32'hFFFF_FFA5);
    rd_reg(pdec_pkg::WAKE_EN_OFFSET);
    chk(rd, 32'hA5);
    wr(pdec_pkg::WAKE_LVL_OFFSET, 32'h5A);
    rd_reg(pdec_pkg::WAKE_LVL_OFFSET);
    chk(rd, 32'h5A);
    wr(4'h2, 32'hFF);
    rd_reg(4'h2);
    chk(rd, 32'h0);
    rd_reg(pdec_pkg::STATUS_OFFSET);
    chk(rd, 32'h30);
  endtask : t_regs
  task automatic t_nmi;
    pd(1'b0, 1'b0, 6'h39);
    @(posedge ref_clk);
    #1 chk({26'h0, outs}, 32'h38);
    rd_reg(pdec_pkg::STATUS_OFFSET);
    chk(rd, 32'h130);
    pins(1'b0, 8'h00);
    pd(1'b0, 1'b0, 6'h04);
    pins(1'b1, 8'h00);
    chk({26'h0, outs}, 32'h38);
  endtask : t_nmi
  // pin 2 is high-active, pin 0 low-active
  task automatic t_wake;
    wr(pdec_pkg::CTRL_OFFSET, 32'h19);
    wr(pdec_pkg::WAKE_EN_OFFSET, 32'h05);
    wr(pdec_pkg::WAKE_LVL_OFFSET, 32'h04);
    pins(1'b0, 8'h05);
    pd(1'b0, 1'b0, 6'h39);
    pins(1'b0, 8'h00);
    pd(1'b0, 1'b0, 6'h39);
    pins(1'b0, 8'hFB);
    pd(1'b0, 1'b0, 6'h04);
    pins(1'b0, 8'h05);
    chk({26'h0, outs}, 32'h38);
    rst();
  endtask : t_wake
  // software guidance is broken on purpose here to reach the stall
  task automatic t_quasi;
    wr(pdec_pkg::CTRL_OFFSET, 32'h14);
    pd(1'b1, 1'b0, 6'h02);
    pd(1'b0, 1'b0, 6'h02);
    wdog(1'b1);
    chk({26'h0, outs}, 32'h02);
    pins(1'b0, 8'h00);
    chk({26'h0, outs}, 32'h04);
    rst();
  endtask : t_quasi
  // mux bus with tristate wait set: only the prior write stalls
  task automatic t_prev;
    wr(pdec_pkg::CTRL_OFFSET, 32'h16);
    pd(1'b1, 1'b0, 6'h39);
    pd(1'b1, 1'b1, 6'h02);
    rst();
  endtask : t_prev
  task automatic t_wdt;
    wr(pdec_pkg::CTRL_OFFSET, 32'h08);
    wdog(1'b0);
    wr(pdec_pkg::CTRL_OFFSET, 32'h18);
    wdog(1'b1);
  endtask : t_wdt
  task automatic t_drain;
    wr(pdec_pkg::CTRL_OFFSET, 32'h1C);
    bus_kick();
    pd(1'b1, 1'b1, 6'h00);
    repeat (20) if (fetch_enable !== 1'b1) #10;
    chk({26'h0, outs}, 32'h39);
    rd_reg(pdec_pkg::STATUS_OFFSET);
    chk(rd, 32'h130);
    pins(1'b0, 8'h00);
    bus_kick();
    pd(1'b1, 1'b1, 6'h00);
    repeat (20) if (power_down_active !== 1'b1) #10;
    chk({26'h0, outs}, 32'h04);
  endtask : t_drain
  task automatic end_of_test;
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  initial begin
    rst();
    t_regs();
    t_nmi();
    t_wake();
    t_quasi();
    t_prev();
    t_wdt();
    t_drain();
    end_of_test();
  end
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
